// ### inc/dsc_cfg.svh
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// Frame layout
`define DSC_FRAME_W       24
`define DSC_CODE_W        16
`define DSC_CMD_MSB       23
`define DSC_CMD_LSB       18
`define DSC_PWR_HI        17
`define DSC_PWR_LO        16

// Edge counts within a frame
`define DSC_CNT_W         5
`define DSC_LAST_BIT      5'h17
`define DSC_REF_EDGE      5'h19
`define DSC_CNT_MAX       5'h1F

// Special command words
`define DSC_REF_OFF_WORD  24'h480401
`define DSC_REF_ARM_WORD  24'h4C0400

// Reset values
`define DSC_CODE_RST      16'h0000
`define DSC_WORD_RST      24'h000000

// Timing: core clock rate and wake delay from power-down
`define DSC_CLK_KHZ       20000
`define DSC_WAKE_NS       2500
`define DSC_WAKE_CYC      ((`DSC_WAKE_NS * `DSC_CLK_KHZ + 999999) / 1000000)
`define DSC_WAKE_W        7

`endif

// ### inc/dsc_pkg.sv
package dsc_pkg;

	// Power-mode select field
	typedef enum logic [1:0] {
		DSC_PWR_NORMAL = 2'h0,
		DSC_PWR_1K     = 2'h1,
		DSC_PWR_100K   = 2'h2,
		DSC_PWR_HIZ    = 2'h3
	} dsc_pwr_t;

	// Output stage state, Gray coded along run -> down -> wake; wake -> run flips both bits
	typedef enum logic [1:0] {
		DSC_ST_RUN  = 2'h0,
		DSC_ST_DOWN = 2'h1,
		DSC_ST_WAKE = 2'h3
	} dsc_state_t;

	// One captured frame
	typedef struct packed {
		logic [5:0]  cmd;
		dsc_pwr_t    pwrMode;
		logic [15:0] code;
	} dsc_frame_t;

	// Analog control bundle
	typedef struct packed {
		logic        analogOn;
		logic        ampDrive;
		dsc_pwr_t    termSel;
		logic        refOn;
	} dsc_ana_t;

endpackage : dsc_pkg

// ### core/dsc_serial_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"

// What this block does
// (R1) Host lowers frame select before the first data bit of a frame.
// (R2) Data line sampled on each of the first 24 falling shift-clock edges into 24-bit register.
// (R3) Shift clock up to 30 MHz; link logic runs directly on it.
// (R4) On the 24th falling edge the last bit enters and the command runs.
// (R5) Host keeps frame select high at least 33 ns between frames.
// (R6) A new frame starts only after frame select falls again.
// (R7) Ordinary code updates carry zeros in the six top frame bits.
// (R8) Power-mode bits come from frame bits 17 and 16.
// (R9) Modes: normal, 1k to ground, 100k to ground, high impedance.
// (R10) Any power-down mode shuts analog down and switches output to termination.
// (R11) Power-down leaves the stored 16-bit code unchanged.
// (R12) Output resumes after a wake delay of about 2.5 us.
// (R13) Normal commit copies the low 16 frame bits into the code register.
// (R14) Frame select rising before edge 24 clears the frame; nothing changes.
// (R15) Power-up clears every register except the reference and analog flags, which load ones, and holds output at zero scale.
// (R16) Word 0x480401 switches the on-chip reference off.
// (R17) Word 0x4C0400 followed by a second command frame re-enables it.
// (R18) Reference commands need 26 falling edges with frame select low.
// (R19) With the reference off, its pin is released to high impedance.
// (R20) Reference returns on power cycle or after both enable frames.
// (R21) Frame bits arrive most significant first.
// (R22) Edges after the 24th do not alter the executed command.
module dsc_serial_ctrl (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               sclk,
	input  wire logic               frameSelN,
	input  wire logic               serialData,
	output var  logic [15:0]        dacCode,
	output var  dsc_pkg::dsc_pwr_t  pwrMode,
	output var  logic               analogOn,
	output var  logic               ampDrive,
	output var  dsc_pkg::dsc_pwr_t  termSel,
	output var  logic               refPinOe,
	output var  logic               analogOutPinOe
);

	//------------------------------------------------------------
	// Decoding helpers
	//------------------------------------------------------------

	// An all-zero command field marks an ordinary code update
	function automatic logic isCodeFrame(input logic [5:0] cmd);
		return (cmd == 6'h00); // (R7)
	endfunction : isCodeFrame

	// Only normal mode lets the amplifier near the output pin
	function automatic logic isNormal(input dsc_pkg::dsc_pwr_t mode);
		return (mode == dsc_pkg::DSC_PWR_NORMAL); // (R9)
	endfunction : isNormal

	//------------------------------------------------------------
	// Link domain (falling shift clock)
	//------------------------------------------------------------

	// Frame select high clears the frame; no shift-clock edge is needed for it
	logic linkRstN;
	assign linkRstN = nrst & ~frameSelN; // (R14) (R6)

	logic [`DSC_CNT_W-1:0]   edgeCnt_r;
	logic [`DSC_CNT_W-1:0]   edgeCnt_nxt;
	logic [`DSC_FRAME_W-1:0] shift_r;
	logic [`DSC_FRAME_W-1:0] shift_nxt;
	dsc_pkg::dsc_frame_t     word_r;
	dsc_pkg::dsc_frame_t     word_nxt;
	logic                    cmtTgl_r;
	logic                    cmtTgl_nxt;
	logic                    refTgl_r;
	logic                    refTgl_nxt;

	// Next-state logic of the shifter
	always_comb begin
		edgeCnt_nxt = edgeCnt_r;
		shift_nxt   = shift_r;
		word_nxt    = word_r;
		cmtTgl_nxt  = cmtTgl_r;
		refTgl_nxt  = refTgl_r;
		if (edgeCnt_r != `DSC_CNT_MAX) begin
			edgeCnt_nxt = edgeCnt_r + 5'h01;
		end
		if (edgeCnt_r <= `DSC_LAST_BIT) begin
			shift_nxt = {shift_r[`DSC_FRAME_W-2:0], serialData}; // (R2) (R21)
		end
		if (edgeCnt_r == `DSC_LAST_BIT) begin
			// Last bit is taken in together with the commit
			word_nxt   = {shift_r[`DSC_FRAME_W-2:0], serialData}; // (R4)
			cmtTgl_nxt = ~cmtTgl_r; // (R4)
		end
		// Reference commands act only once two extra edges were seen
		if (edgeCnt_r == `DSC_REF_EDGE && !isCodeFrame(word_r.cmd)) begin
			refTgl_nxt = ~refTgl_r; // (R18)
		end
	end

	// Register stage; later edges only saturate the counter
	always_ff @(negedge sclk or negedge linkRstN) begin // (R3)
		if (!linkRstN) begin
			edgeCnt_r <= 5'h00;
			shift_r   <= `DSC_WORD_RST;
		end else begin
			edgeCnt_r <= edgeCnt_nxt; // (R22)
			shift_r   <= shift_nxt;
		end
	end

	// Committed word and event toggles survive frame select rising
	always_ff @(negedge sclk or negedge nrst) begin
		if (!nrst) begin
			word_r   <= `DSC_WORD_RST;
			cmtTgl_r <= 1'b0;
			refTgl_r <= 1'b0;
		end else if (!frameSelN) begin
			word_r   <= word_nxt;
			cmtTgl_r <= cmtTgl_nxt;
			refTgl_r <= refTgl_nxt;
		end else begin
			word_r   <= word_r;
			cmtTgl_r <= cmtTgl_r;
			refTgl_r <= refTgl_r;
		end
	end

	//------------------------------------------------------------
	// Core reset release
	//------------------------------------------------------------

	// Reset enters at once but leaves on a clock edge; a raw release near
	// an edge could let some core flops start one cycle before others
	logic [1:0] rstSync_r;
	logic [1:0] rstSync_nxt;
	logic       coreRstN;

	// Shift in ones once the pin is released
	always_comb begin
		rstSync_nxt = {rstSync_r[0], 1'b1};
	end

	// The pin itself clears the chain at once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= rstSync_nxt;
		end
	end

	// Only the second flop feeds the core reset
	assign coreRstN = rstSync_r[1];

	//------------------------------------------------------------
	// Crossing into the core clock
	//------------------------------------------------------------

	// Toggles pass two flops; the word is stable long before they arrive,
	// because a new commit needs another 24 shift-clock edges
	logic [2:0] cmtSync_r;
	logic [2:0] cmtSync_nxt;
	logic [2:0] refSync_r;
	logic [2:0] refSync_nxt;

	// Each chain shifts its toggle one flop per core clock
	always_comb begin
		cmtSync_nxt = {cmtSync_r[1:0], cmtTgl_r};
		refSync_nxt = {refSync_r[1:0], refTgl_r};
	end

	// Chains start equal to the reset toggles, so no false event follows reset
	always_ff @(posedge clk or negedge coreRstN) begin
		if (!coreRstN) begin
			cmtSync_r <= 3'h0;
			refSync_r <= 3'h0;
		end else begin
			cmtSync_r <= cmtSync_nxt;
			refSync_r <= refSync_nxt;
		end
	end

	// One-cycle event per toggle, taken past the second flop
	logic cmtEvt;
	logic refEvt;
	assign cmtEvt = cmtSync_r[2] ^ cmtSync_r[1];
	assign refEvt = refSync_r[2] ^ refSync_r[1];

	//------------------------------------------------------------
	// Command execution
	//------------------------------------------------------------

	logic [15:0]              code_r;
	logic [15:0]              code_nxt;
	dsc_pkg::dsc_pwr_t        mode_r;
	dsc_pkg::dsc_pwr_t        mode_nxt;
	logic                     refOn_r;
	logic                     refOn_nxt;
	logic                     refArm_r;
	logic                     refArm_nxt;
	dsc_pkg::dsc_frame_t      seen;

	// Word sampled here is static: link side wrote it on the commit toggle's edge, two edges before the reference toggle, two flops ahead of either event
	assign seen = word_r;

	always_comb begin
		code_nxt   = code_r;
		mode_nxt   = mode_r;
		refOn_nxt  = refOn_r;
		refArm_nxt = refArm_r;
		// Ordinary update only when the command field is all zeros
		if (cmtEvt && isCodeFrame(seen.cmd)) begin
			mode_nxt = seen.pwrMode; // (R8) (R7)
			if (isNormal(seen.pwrMode)) begin
				code_nxt = seen.code; // (R13)
			end
			// Power-down keeps the previous code
			// (R11)
		end
		if (refEvt) begin
			if (seen == `DSC_REF_OFF_WORD) begin
				refOn_nxt  = 1'b0; // (R16)
				refArm_nxt = 1'b0;
			end else if (seen == `DSC_REF_ARM_WORD) begin
				refArm_nxt = 1'b1; // (R17)
			end else if (refArm_r) begin
				refOn_nxt  = 1'b1; // (R20)
				refArm_nxt = 1'b0;
			end else begin
				refArm_nxt = 1'b0;
			end
		end
	end

	// Reference defaults on; everything else starts at zero
	always_ff @(posedge clk or negedge coreRstN) begin
		if (!coreRstN) begin
			code_r   <= `DSC_CODE_RST; // (R15)
			mode_r   <= dsc_pkg::DSC_PWR_NORMAL;
			refOn_r  <= 1'b1; // (R20)
			refArm_r <= 1'b0;
		end else begin
			code_r   <= code_nxt;
			mode_r   <= mode_nxt;
			refOn_r  <= refOn_nxt;
			refArm_r <= refArm_nxt;
		end
	end

	//------------------------------------------------------------
	// Output stage state machine
	//------------------------------------------------------------

	localparam logic [`DSC_WAKE_W-1:0] WAKE_CYC = `DSC_WAKE_W'(`DSC_WAKE_CYC);

	dsc_pkg::dsc_state_t     st_r;
	dsc_pkg::dsc_state_t     st_nxt;
	logic [`DSC_WAKE_W-1:0]  wakeCnt_r;
	logic [`DSC_WAKE_W-1:0]  wakeCnt_nxt;

	// Amplifier is kept off until the wake delay has run out
	always_comb begin
		st_nxt      = st_r;
		wakeCnt_nxt = wakeCnt_r;
		case (st_r)
			dsc_pkg::DSC_ST_RUN: begin
				if (!isNormal(mode_r)) begin
					st_nxt = dsc_pkg::DSC_ST_DOWN; // (R10)
				end
			end
			dsc_pkg::DSC_ST_DOWN: begin
				if (isNormal(mode_r)) begin
					st_nxt      = dsc_pkg::DSC_ST_WAKE;
					wakeCnt_nxt = WAKE_CYC; // (R12)
				end
			end
			dsc_pkg::DSC_ST_WAKE: begin
				if (!isNormal(mode_r)) begin
					st_nxt = dsc_pkg::DSC_ST_DOWN;
				end else if (wakeCnt_r <= `DSC_WAKE_W'(1)) begin
					st_nxt = dsc_pkg::DSC_ST_RUN; // (R12)
				end else begin
					wakeCnt_nxt = wakeCnt_r - `DSC_WAKE_W'(1);
				end
			end
			default: begin
				st_nxt = dsc_pkg::DSC_ST_RUN;
			end
		endcase
	end

	// State and wake counter registers
	always_ff @(posedge clk or negedge coreRstN) begin
		if (!coreRstN) begin
			st_r      <= dsc_pkg::DSC_ST_RUN;
			wakeCnt_r <= `DSC_WAKE_W'(0);
		end else begin
			st_r      <= st_nxt;
			wakeCnt_r <= wakeCnt_nxt;
		end
	end

	//------------------------------------------------------------
	// Registered outputs
	//------------------------------------------------------------

	dsc_pkg::dsc_ana_t ana_r;
	dsc_pkg::dsc_ana_t ana_nxt;
	logic [15:0]       codeOut_r;
	dsc_pkg::dsc_pwr_t pwrOut_r;

	// Termination follows the mode; normal mode selects no termination
	always_comb begin
		ana_nxt.analogOn = isNormal(mode_r); // (R10)
		ana_nxt.ampDrive = (st_nxt == dsc_pkg::DSC_ST_RUN) &&
		                   (mode_r == dsc_pkg::DSC_PWR_NORMAL); // (R12)
		ana_nxt.termSel  = mode_r; // (R9)
		ana_nxt.refOn    = refOn_r; // (R19)
	end

	// Mode, code and controls leave one flop stage together
	always_ff @(posedge clk or negedge coreRstN) begin
		if (!coreRstN) begin
			ana_r     <= '{analogOn: 1'b1, ampDrive: 1'b1,
			               termSel: dsc_pkg::DSC_PWR_NORMAL, refOn: 1'b1};
			codeOut_r <= `DSC_CODE_RST; // (R15)
			pwrOut_r  <= dsc_pkg::DSC_PWR_NORMAL;
		end else begin
			ana_r     <= ana_nxt;
			codeOut_r <= code_r;
			pwrOut_r  <= mode_r;
		end
	end

	// Pins come straight from the output flops
	assign dacCode        = codeOut_r;
	assign pwrMode        = pwrOut_r;
	assign analogOn       = ana_r.analogOn;
	assign ampDrive       = ana_r.ampDrive;
	assign termSel        = ana_r.termSel;
	assign refPinOe       = ana_r.refOn; // (R19)
	assign analogOutPinOe = ana_r.ampDrive; // (R10)

endmodule : dsc_serial_ctrl
`default_nettype wire

// ### tb/dsc_serial_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Output checker
// ----
module dsc_ctrl_checker (
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              sclk,
	input wire logic              frameSelN,
	input wire logic              serialData,
	input wire logic [15:0]       dacCode,
	input wire dsc_pkg::dsc_pwr_t pwrMode,
	input wire logic              analogOn,
	input wire logic              ampDrive,
	input wire dsc_pkg::dsc_pwr_t termSel,
	input wire logic              refPinOe,
	input wire logic              analogOutPinOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Mode and its controls change on the same edge, so they agree every cycle
	term_sel_a: assert property (termSel == pwrMode)
		else $error("termination differs from mode");
	analog_mode_a: assert property (analogOn == (pwrMode == 2'h0))
		else $error("analog power wrong for mode");
	amp_off_a: assert property (pwrMode != 2'h0 |-> !ampDrive)
		else $error("amplifier drives in power-down");
	oe_match_a: assert property (analogOutPinOe == ampDrive)
		else $error("output enable differs from drive");
	wake_bound_a: assert property (pwrMode == 2'h0 && !ampDrive |-> ##[1:55] ampDrive)
		else $error("wake takes too long");
	wake_min_a: assert property ($rose(ampDrive) |-> !$past(ampDrive, 45))
		else $error("wake too short");
	code_hold_a: assert property ($changed(dacCode) |-> pwrMode == 2'h0)
		else $error("code changed in power-down");
	idle_quiet_a: assert property (frameSelN [*8] |-> $stable(dacCode) && $stable(pwrMode))
		else $error("outputs changed with no frame");
	reset_clear_a: assert property ($rose(nrst) |-> dacCode == 16'h0000 && refPinOe)
		else $error("state not cleared by reset");
endmodule : dsc_ctrl_checker
bind dsc_serial_ctrl dsc_ctrl_checker u_chk (.clk(clk), .nrst(nrst), .sclk(sclk),
	.frameSelN(frameSelN), .serialData(serialData), .dacCode(dacCode), .pwrMode(pwrMode),
	.analogOn(analogOn), .ampDrive(ampDrive), .termSel(termSel), .refPinOe(refPinOe),
	.analogOutPinOe(analogOutPinOe));
`default_nettype wire

// ### tb/dsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Serial host
// ----
module dsc_host_model (
	output var logic sclk,
	output var logic frameSelN,
	output var logic serialData
);
	// Link clock stands high between frames
	initial begin
		sclk = 1'b1;
		frameSelN = 1'b1;
		serialData = 1'b0;
	end
	// Frame of n falling edges; fewer than 24 aborts it
	task automatic frame(input logic [23:0] w, input int n);
		frameSelN = 1'b0;
		#10;
		for (int i = 0; i < n; i++) begin
			serialData = (i < 24) ? w[23 - i] : 1'b0;
			#7 sclk = 1'b0;
			#8 sclk = 1'b1;
		end
		serialData = ~serialData; // Released line shows no stale bit
		#5 frameSelN = 1'b1;
		#40;
	endtask : frame
endmodule : dsc_host_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, g, w); end end
module tb_top;
	logic              clk, nrst, sclk, frameSelN, serialData;
	logic              analogOn, ampDrive, refPinOe, analogOutPinOe;
	logic [15:0]       dacCode, eCode;
	logic [1:0]        eMode;
	logic              eRef, armed;
	dsc_pkg::dsc_pwr_t pwrMode, termSel;
	int                mismatches, tests_run, cycles;
	dsc_serial_ctrl u_dut (.clk(clk), .nrst(nrst), .sclk(sclk), .frameSelN(frameSelN),
		.serialData(serialData), .dacCode(dacCode), .pwrMode(pwrMode), .analogOn(analogOn),
		.ampDrive(ampDrive), .termSel(termSel), .refPinOe(refPinOe),
		.analogOutPinOe(analogOutPinOe));
	dsc_host_model u_host (.sclk(sclk), .frameSelN(frameSelN), .serialData(serialData));
	// ----
	// Expectations
	// ----
	function automatic logic [1:0] modeAfter(logic [23:0] w, int n, logic [1:0] m);
		return (n >= 24 && w[23:18] == 6'h00) ? w[17:16] : m;
	endfunction : modeAfter
	function automatic logic [15:0] codeAfter(logic [23:0] w, int n, logic [15:0] c);
		return (n >= 24 && w[23:16] == 8'h00) ? w[15:0] : c;
	endfunction : codeAfter
	task automatic check_all;
		`CHK(dacCode, eCode)
		`CHK(pwrMode, eMode)
		`CHK(termSel, eMode)
		`CHK(analogOn, eMode == 2'h0)
		`CHK(refPinOe, eRef)
	endtask : check_all
	// Send one frame, update the expected state, then look once it settles
	task automatic put(input logic [23:0] w, input int n);
		@(posedge clk);
		#1;
		u_host.frame(w, n);
		eCode = codeAfter(w, n, eCode);
		eMode = modeAfter(w, n, eMode);
		if (n >= 26) begin
			if (w == `DSC_REF_OFF_WORD) eRef = 1'b0;
			else if (armed && w[23:18] != 6'h00) eRef = 1'b1;
			armed = (w == `DSC_REF_ARM_WORD);
		end
		repeat (10) @(posedge clk);
		#1;
		check_all();
	endtask : put
	task automatic wrap_up;
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// ----
	// Clock, watchdog, sequence
	// ----
	initial clk = 1'b0;
	always #25 clk = ~clk;
	// A hang ends the run as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		nrst = 1'b0;
		{mismatches, tests_run, cycles} = '0;
		{eCode, eMode, armed} = '0;
		eRef = 1'b1;
		void'($urandom(37788));
		repeat (4) @(posedge clk);
		#1 nrst = 1'b1;
		check_all();
		for (int i = 0; i < 8; i++) put({8'h00, 16'($urandom)}, 24);
		put(24'h00FFFF, 24);
		put(24'h000001, 30);
		put({8'h00, 16'($urandom)}, 23);
		for (int m = 1; m < 4; m++) begin
			put({6'h00, 2'(m), 16'($urandom)}, 24);
			`CHK(analogOutPinOe, 1'b0)
		end
		put(24'h001234, 24);
		`CHK(ampDrive, 1'b0)
		repeat (50) @(posedge clk);
		`CHK(analogOutPinOe, 1'b1)
		put(`DSC_REF_OFF_WORD, 24);
		put(`DSC_REF_OFF_WORD, 26);
		put(`DSC_REF_ARM_WORD, 26);
		put(24'h090000, 26);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
